/* File: logic/blank_chop_pkg.sv */
// constants for the blanking, chopping and capture block
package blank_chop_pkg;
    // register byte addresses on the apb bus
    localparam logic [11:0] ADDR_EDGE_BLANK_CONTROL   = 12'h000;
    localparam logic [11:0] ADDR_EDGE_BLANK_DELAY     = 12'h004;
    localparam logic [11:0] ADDR_GENERATOR_AUX_CONTROL = 12'h008;
    localparam logic [11:0] ADDR_TIME_BASE_CAPTURE    = 12'h00c;
    localparam logic [11:0] ADDR_CHOP_DIVIDER         = 12'h010;
    localparam logic [11:0] ADDR_BLANK_STATUS         = 12'h014;

    // edge blank control fields
    localparam int PRIMARY_RISE_TRIGGER_BIT   = 15;
    localparam int PRIMARY_FALL_TRIGGER_BIT   = 14;
    localparam int SECONDARY_RISE_TRIGGER_BIT = 13;
    localparam int SECONDARY_FALL_TRIGGER_BIT = 12;
    localparam int FAULT_EDGE_BLANK_BIT       = 11;
    localparam int LIMIT_EDGE_BLANK_BIT       = 10;
    localparam int BLANK_SOURCE_HIGH_BIT      = 5;
    localparam int BLANK_SOURCE_LOW_BIT       = 4;
    localparam int BLANK_PRIMARY_HIGH_BIT     = 3;
    localparam int BLANK_PRIMARY_LOW_BIT      = 2;
    localparam int BLANK_SECONDARY_HIGH_BIT   = 1;
    localparam int BLANK_SECONDARY_LOW_BIT    = 0;
    localparam logic [15:0] EDGE_BLANK_CONTROL_MASK = 16'hfc3f;

    // edge blank delay field
    localparam int DELAY_LSB   = 3;
    localparam int DELAY_WIDTH = 9;
    localparam logic [15:0] EDGE_BLANK_DELAY_MASK = 16'h0ff8;

    // aux control fields
    localparam int FINE_PERIOD_DISABLE_BIT   = 15;
    localparam int FINE_DUTY_DISABLE_BIT     = 14;
    localparam int BLANK_SOURCE_LSB          = 8;
    localparam int CHOP_SOURCE_LSB           = 2;
    localparam int SELECT_WIDTH              = 4;
    localparam int PRIMARY_CHOP_ENABLE_BIT   = 1;
    localparam int SECONDARY_CHOP_ENABLE_BIT = 0;
    localparam logic [15:0] AUX_CONTROL_MASK = 16'hcf3f;

    // capture field
    localparam int CAPTURE_LSB   = 3;
    localparam int CAPTURE_WIDTH = 13;

    // source select codes
    localparam logic [3:0] SEL_NONE = 4'h0;
    localparam logic [3:0] SEL_GEN1 = 4'h1;
    localparam logic [3:0] SEL_GEN2 = 4'h2;
    localparam logic [3:0] SEL_GEN3 = 4'h3;

    // timing: one delay count and the blanking clock period
    localparam real DELAY_STEP_NS  = 8.32;
    localparam real CLK_PERIOD_NS  = 20.0;
    localparam int  DELAY_STEP_CYCLES =
        (int'(DELAY_STEP_NS / CLK_PERIOD_NS) < 1) ? 1 : int'(DELAY_STEP_NS / CLK_PERIOD_NS);

    localparam logic [15:0] CHOP_DIVIDER_RESET = 16'h0010;
endpackage

/* File: logic/edge_blank_timer.sv */
// leading-edge blanking counter, restarted by each enabled output edge
`timescale 1ns/1ns
module edge_blank_timer
    import blank_chop_pkg::*;
#(
    parameter int WIDTH = DELAY_WIDTH
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             trigger,
    input  wire logic [WIDTH-1:0] delay,
    output logic                  active
);
    logic [WIDTH-1:0] remaining;

    // a new edge reloads the count even mid-interval
    always_ff @(posedge clk) begin
        if (rst) begin
            remaining <= '0;
        end else if (trigger) begin
            remaining <= delay;
        end else if (remaining != '0) begin
            remaining <= remaining - WIDTH'(1);
        end
    end

    assign active = trigger ? (delay != '0) : (remaining != '0);
endmodule

/* File: logic/blank_chop_capture.sv */
// blanking, chop gating and time base capture for one pwm generator
//
// How it works
// - blank inputs while primary output high or low, per enable bits 3, 2
// - blank inputs while secondary output high or low, per enable bits 1, 0
// - selected state blank signal blocks inputs only as its enables allow
// - blank source code 0 disables, 1..3 pick generator primaries, rest reserved
// - nine-bit blanking delay at bits 11..3, one 20 ns clock per count rather than 8.32 ns
// - period fine-resolution disable bit 15 turns off that logic
// - duty fine-resolution disable bit 14 turns off that logic
// - chop source 0 internal generator, 1..3 generator primaries, rest reserved
// - selected chop source gates the outputs that have chopping on
// - primary chopped only with bit 1, secondary only with bit 0
// - limit leading edge copies time base into capture bits 15..3
// - capture serves the primary output only
// - capture waits until edge blanking of the limit input is over
// - capture resolution at least 8.32 ns per count
// - capture works only while external period reset is zero
// - unimplemented bits of delay, aux and capture read zero
// - four edge enables let output edges restart the blanking counter
// - separate enables apply edge blanking to fault and to limit
// - source high and low enables blank while selected signal high or low
`timescale 1ns/1ns
module blank_chop_capture
    import blank_chop_pkg::*;
(
    input  wire logic                     CLK,
    input  wire logic                     SYS_RST,
    // apb slave
    input  wire logic                     PSEL,
    input  wire logic                     PENABLE,
    input  wire logic                     PWRITE,
    input  wire logic [11:0]              PADDR,
    input  wire logic [31:0]              PWDATA,
    output logic      [31:0]              PRDATA,
    output logic                          PREADY,
    output logic                          PSLVERR,
    // pwm core side, same clock
    input  wire logic                     PRIMARY_OUTPUT,
    input  wire logic                     SECONDARY_OUTPUT,
    input  wire logic [2:0]               GENERATOR_PRIMARIES,
    input  wire logic [CAPTURE_WIDTH-1:0] TIME_BASE,
    input  wire logic                     EXTERNAL_PERIOD_RESET,
    // fault and limit arrive from pins
    input  wire logic                     FAULT_IN,
    input  wire logic                     LIMIT_IN,
    // qualified results
    output logic                          FAULT_OUT,
    output logic                          LIMIT_OUT,
    output logic                          PRIMARY_GATED,
    output logic                          SECONDARY_GATED,
    output logic                          FINE_PERIOD_ENABLE,
    output logic                          FINE_DUTY_ENABLE
);
    logic [15:0] edge_blank_control;
    logic [15:0] edge_blank_delay;
    logic [15:0] generator_aux_control;
    logic [CAPTURE_WIDTH-1:0] captured_time_base;
    logic [15:0] chop_divider;
    logic [15:0] chop_count;
    logic        chop_clock;

    logic [2:0] fault_sync;
    logic [2:0] limit_sync;
    logic       fault_level;
    logic       limit_level;
    logic       limit_prev;

    logic primary_prev;
    logic secondary_prev;
    logic edge_trigger;
    logic edge_active;
    logic state_blank;
    logic source_signal;
    logic chop_signal;
    logic fault_blanked;
    logic limit_blanked;
    logic limit_clean;

    logic [3:0] state_blank_source_select;
    logic [3:0] chop_source_select;
    logic       wr_en;
    logic       rd_en;
    logic       addr_hit;

    // maps a select code to a generator primary; reserved codes give zero
    function automatic logic pick_primary(input logic [3:0] sel, input logic [2:0] prim);
        logic r;
        r = 1'b0;
        case (sel)
            SEL_GEN1: r = prim[0];
            SEL_GEN2: r = prim[1];
            SEL_GEN3: r = prim[2];
            default:  r = 1'b0;
        endcase
        return r;
    endfunction

    function automatic logic [15:0] word_of(input logic [11:0] a);
        logic [15:0] v;
        v = 16'h0000;
        case (a)
            ADDR_EDGE_BLANK_CONTROL:    v = edge_blank_control;
            ADDR_EDGE_BLANK_DELAY:      v = edge_blank_delay;
            ADDR_GENERATOR_AUX_CONTROL: v = generator_aux_control;
            ADDR_TIME_BASE_CAPTURE:     v = {captured_time_base, 3'h0};
            ADDR_CHOP_DIVIDER:          v = chop_divider;
            ADDR_BLANK_STATUS:          v = {12'h000, chop_clock, edge_active,
                                             fault_blanked, limit_blanked};
            default:                    v = 16'h0000;
        endcase
        return v;
    endfunction

    assign state_blank_source_select = generator_aux_control[BLANK_SOURCE_LSB +: SELECT_WIDTH];
    assign chop_source_select = generator_aux_control[CHOP_SOURCE_LSB +: SELECT_WIDTH];

    // apb: zero wait states, unmapped addresses flag an error
    assign addr_hit = (PADDR == ADDR_EDGE_BLANK_CONTROL) || (PADDR == ADDR_EDGE_BLANK_DELAY)
                   || (PADDR == ADDR_GENERATOR_AUX_CONTROL) || (PADDR == ADDR_TIME_BASE_CAPTURE)
                   || (PADDR == ADDR_CHOP_DIVIDER) || (PADDR == ADDR_BLANK_STATUS);
    assign PREADY  = 1'b1;
    assign PSLVERR = PSEL && PENABLE && !addr_hit;
    assign wr_en   = PSEL && PENABLE && PWRITE && addr_hit;
    assign rd_en   = PSEL && !PENABLE && !PWRITE;

    // write masks keep unimplemented bits at zero
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            edge_blank_control    <= 16'h0000;
            edge_blank_delay      <= 16'h0000;
            generator_aux_control <= 16'h0000;
            chop_divider          <= CHOP_DIVIDER_RESET;
        end else if (wr_en) begin
            case (PADDR)
                ADDR_EDGE_BLANK_CONTROL:
                    edge_blank_control <= PWDATA[15:0] & EDGE_BLANK_CONTROL_MASK;
                ADDR_EDGE_BLANK_DELAY:
                    edge_blank_delay <= PWDATA[15:0] & EDGE_BLANK_DELAY_MASK;
                ADDR_GENERATOR_AUX_CONTROL:
                    generator_aux_control <= PWDATA[15:0] & AUX_CONTROL_MASK;
                ADDR_CHOP_DIVIDER:
                    chop_divider <= PWDATA[15:0];
                default: ;
            endcase
        end
    end

    // read data registered in the setup cycle, valid through access
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            PRDATA <= 32'h00000000;
        end else if (rd_en) begin
            PRDATA <= {16'h0000, word_of(PADDR)};
        end
    end

    // fault and limit come off pins: three stages, change taken when last two agree
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            fault_sync  <= 3'h0;
            limit_sync  <= 3'h0;
            fault_level <= 1'b0;
            limit_level <= 1'b0;
        end else begin
            fault_sync <= {fault_sync[1:0], FAULT_IN};
            limit_sync <= {limit_sync[1:0], LIMIT_IN};
            if (fault_sync[2] == fault_sync[1]) begin
                fault_level <= fault_sync[2];
            end
            if (limit_sync[2] == limit_sync[1]) begin
                limit_level <= limit_sync[2];
            end
        end
    end

    // output edge detection for the blanking counter
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            primary_prev   <= 1'b0;
            secondary_prev <= 1'b0;
        end else begin
            primary_prev   <= PRIMARY_OUTPUT;
            secondary_prev <= SECONDARY_OUTPUT;
        end
    end

    assign edge_trigger =
        (edge_blank_control[PRIMARY_RISE_TRIGGER_BIT]   && PRIMARY_OUTPUT && !primary_prev)
     || (edge_blank_control[PRIMARY_FALL_TRIGGER_BIT]   && !PRIMARY_OUTPUT && primary_prev)
     || (edge_blank_control[SECONDARY_RISE_TRIGGER_BIT] && SECONDARY_OUTPUT && !secondary_prev)
     || (edge_blank_control[SECONDARY_FALL_TRIGGER_BIT] && !SECONDARY_OUTPUT
         && secondary_prev);

    // one count per clock: the 20 ns clock is coarser than 8.32 ns, so the
    // programmed count is a floor in clock periods, not a literal 8.32 ns step
    edge_blank_timer #(
        .WIDTH (DELAY_WIDTH)
    ) u_edge_blank_timer (
        .clk     (CLK),
        .rst     (SYS_RST),
        .trigger (edge_trigger),
        .delay   (edge_blank_delay[DELAY_LSB +: DELAY_WIDTH]),
        .active  (edge_active)
    );

    assign source_signal = pick_primary(state_blank_source_select, GENERATOR_PRIMARIES);

    // state blanking; code zero and reserved codes mean no source, so the
    // source enables do nothing instead of blanking on a dead-low signal
    assign state_blank =
        (edge_blank_control[BLANK_PRIMARY_HIGH_BIT]   && PRIMARY_OUTPUT)
     || (edge_blank_control[BLANK_PRIMARY_LOW_BIT]    && !PRIMARY_OUTPUT)
     || (edge_blank_control[BLANK_SECONDARY_HIGH_BIT] && SECONDARY_OUTPUT)
     || (edge_blank_control[BLANK_SECONDARY_LOW_BIT]  && !SECONDARY_OUTPUT)
     || ((state_blank_source_select inside {SEL_GEN1, SEL_GEN2, SEL_GEN3})
         && ((edge_blank_control[BLANK_SOURCE_HIGH_BIT] && source_signal)
          || (edge_blank_control[BLANK_SOURCE_LOW_BIT] && !source_signal)));

    assign fault_blanked = state_blank
                        || (edge_active && edge_blank_control[FAULT_EDGE_BLANK_BIT]);
    assign limit_blanked = state_blank
                        || (edge_active && edge_blank_control[LIMIT_EDGE_BLANK_BIT]);

    assign limit_clean = limit_level && !limit_blanked;

    // qualified inputs registered toward the core
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            FAULT_OUT <= 1'b0;
            LIMIT_OUT <= 1'b0;
        end else begin
            FAULT_OUT <= fault_level && !fault_blanked;
            LIMIT_OUT <= limit_clean;
        end
    end

    // capture sees only the post-blanking limit, so a masked edge captures only if limit is still high when blanking ends
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            limit_prev         <= 1'b0;
            captured_time_base <= '0;
        end else begin
            limit_prev <= limit_clean;
            if (limit_clean && !limit_prev && !EXTERNAL_PERIOD_RESET) begin
                captured_time_base <= TIME_BASE;
            end
        end
    end

    // internal chop clock: toggles every chop_divider cycles; zero parks it low
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            chop_count <= 16'h0000;
            chop_clock <= 1'b0;
        end else if (chop_divider == 16'h0000) begin
            // stopped means parked low, not frozen at whatever phase it had
            chop_count <= 16'h0000;
            chop_clock <= 1'b0;
        end else if (chop_count >= chop_divider - 16'h0001) begin
            chop_count <= 16'h0000;
            chop_clock <= !chop_clock;
        end else begin
            chop_count <= chop_count + 16'h0001;
        end
    end

    assign chop_signal = (chop_source_select == SEL_NONE)
                       ? chop_clock
                       : pick_primary(chop_source_select, GENERATOR_PRIMARIES);

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            PRIMARY_GATED   <= 1'b0;
            SECONDARY_GATED <= 1'b0;
        end else begin
            PRIMARY_GATED <= PRIMARY_OUTPUT
                && (!generator_aux_control[PRIMARY_CHOP_ENABLE_BIT] || chop_signal);
            SECONDARY_GATED <= SECONDARY_OUTPUT
                && (!generator_aux_control[SECONDARY_CHOP_ENABLE_BIT] || chop_signal);
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            FINE_PERIOD_ENABLE <= 1'b1;
            FINE_DUTY_ENABLE   <= 1'b1;
        end else begin
            FINE_PERIOD_ENABLE <= !generator_aux_control[FINE_PERIOD_DISABLE_BIT];
            FINE_DUTY_ENABLE   <= !generator_aux_control[FINE_DUTY_DISABLE_BIT];
        end
    end
endmodule

/* File: sim/blank_chop_capture_asserts.sv */
// concurrent checks on the bus and output ports of the blanking block
`timescale 1ns/1ns
module blank_chop_capture_asserts
    import blank_chop_pkg::*;
(
    input wire logic        CLK,
    input wire logic        SYS_RST,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic        PREADY,
    input wire logic        PSLVERR,
    input wire logic        PRIMARY_OUTPUT,
    input wire logic        SECONDARY_OUTPUT,
    input wire logic        PRIMARY_GATED,
    input wire logic        SECONDARY_GATED,
    input wire logic        FINE_PERIOD_ENABLE,
    input wire logic        FINE_DUTY_ENABLE
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);

    sequence access_s;
        PSEL && PENABLE;
    endsequence
    sequence read_s(logic [11:0] a);
        access_s ##0 (!PWRITE && PADDR == a);
    endsequence
    sequence aux_write_s;
        access_s ##0 (PWRITE && PADDR == ADDR_GENERATOR_AUX_CONTROL);
    endsequence

    AST_PREADY_ZERO_WAIT: assert property (access_s |-> PREADY)
        else $error("access phase without ready");
    AST_UNMAPPED_ERROR: assert property (access_s ##0 (PADDR > 12'h014) |-> PSLVERR)
        else $error("unmapped access without error");
    AST_MAPPED_NO_ERROR: assert property (access_s ##0 (PADDR <= 12'h014 && PADDR[1:0] == 2'h0)
        |-> !PSLVERR) else $error("mapped access flagged as error");
    AST_UNMAPPED_READS_ZERO: assert property (access_s ##0 (!PWRITE && PADDR > 12'h014)
        |-> PRDATA == 32'h0) else $error("unmapped read not zero");
    AST_DELAY_UNUSED_ZERO: assert property (read_s(ADDR_EDGE_BLANK_DELAY)
        |-> (PRDATA & ~{16'h0, EDGE_BLANK_DELAY_MASK}) == 32'h0) else $error("delay pad bits set");
    AST_AUX_UNUSED_ZERO: assert property (read_s(ADDR_GENERATOR_AUX_CONTROL)
        |-> (PRDATA & ~{16'h0, AUX_CONTROL_MASK}) == 32'h0) else $error("aux pad bits set");
    AST_CAPTURE_UNUSED_ZERO: assert property (read_s(ADDR_TIME_BASE_CAPTURE)
        |-> PRDATA[2:0] == 3'h0 && PRDATA[31:16] == 16'h0) else $error("capture pad bits set");
    AST_READ_DATA_HOLDS: assert property (!(PSEL && !PENABLE && !PWRITE) |=> $stable(PRDATA))
        else $error("read data changed outside a read");
    AST_FINE_FOLLOWS_AUX: assert property (aux_write_s |-> ##2
        (FINE_PERIOD_ENABLE == !$past(PWDATA[15], 2) && FINE_DUTY_ENABLE == !$past(PWDATA[14], 2)))
        else $error("fine enables do not follow aux write");
    AST_PRIMARY_GATE: assert property (PRIMARY_GATED |-> $past(PRIMARY_OUTPUT))
        else $error("primary gated high while output low");
    AST_SECONDARY_GATE: assert property (SECONDARY_GATED |-> $past(SECONDARY_OUTPUT))
        else $error("secondary gated high while output low");
endmodule

/* File: sim/blank_chop_capture_tb_top.sv */
// self-checking bench for the blanking, chop and capture block
`timescale 1ns/1ns
module blank_chop_capture_tb_top
    import blank_chop_pkg::*;
;
    logic                     CLK, SYS_RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
    logic [11:0]              PADDR;
    logic [31:0]              PWDATA, PRDATA;
    logic                     PRIMARY_OUTPUT, SECONDARY_OUTPUT, EXTERNAL_PERIOD_RESET;
    logic [2:0]               GENERATOR_PRIMARIES;
    logic [CAPTURE_WIDTH-1:0] TIME_BASE;
    logic                     FAULT_IN, LIMIT_IN, FAULT_OUT, LIMIT_OUT;
    logic                     PRIMARY_GATED, SECONDARY_GATED, FINE_PERIOD_ENABLE, FINE_DUTY_ENABLE;
    int                       num_errors, comparisons;

    blank_chop_capture i_blank_chop_capture (.CLK(CLK), .SYS_RST(SYS_RST), .PSEL(PSEL),
        .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
        .PREADY(PREADY), .PSLVERR(PSLVERR), .PRIMARY_OUTPUT(PRIMARY_OUTPUT),
        .SECONDARY_OUTPUT(SECONDARY_OUTPUT), .GENERATOR_PRIMARIES(GENERATOR_PRIMARIES),
        .TIME_BASE(TIME_BASE), .EXTERNAL_PERIOD_RESET(EXTERNAL_PERIOD_RESET),
        .FAULT_IN(FAULT_IN), .LIMIT_IN(LIMIT_IN), .FAULT_OUT(FAULT_OUT), .LIMIT_OUT(LIMIT_OUT),
        .PRIMARY_GATED(PRIMARY_GATED), .SECONDARY_GATED(SECONDARY_GATED),
        .FINE_PERIOD_ENABLE(FINE_PERIOD_ENABLE), .FINE_DUTY_ENABLE(FINE_DUTY_ENABLE));

    always #10 CLK = ~CLK;

    task final_report;
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task cyc(input int n);
        repeat (n) @(posedge CLK);
    endtask

    // entered just after an edge; ends one edge after release so strobes never double up
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
             output logic [31:0] r, output logic e);
        int n;
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= wr;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK);
        PENABLE <= 1'b1;
        n = 0;
        do begin
            @(posedge CLK);
            n++;
        end while (PREADY !== 1'b1 && n < 50);
        if (PREADY !== 1'b1) begin
            num_errors++;
            $display("MISMATCH at %0t: bus answer never came", $time);
            final_report();
        end
        r = PRDATA;
        e = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        @(posedge CLK);
    endtask

    task wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask

    task rdc(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r, exp);
    endtask

    initial begin
        int          i, lev, sel, m, en, cnt;
        logic [2:0]  oh;
        logic [31:0] r;
        logic        e, prev;
        CLK = 0; SYS_RST = 1; PSEL = 0; PENABLE = 0; PWRITE = 0; PADDR = 0; PWDATA = 0;
        PRIMARY_OUTPUT = 0; SECONDARY_OUTPUT = 0; GENERATOR_PRIMARIES = 0; TIME_BASE = 0;
        EXTERNAL_PERIOD_RESET = 0; FAULT_IN = 0; LIMIT_IN = 0; num_errors = 0; comparisons = 0;
        cyc(16);
        SYS_RST <= 1'b0;
        cyc(1);
        rdc(ADDR_EDGE_BLANK_DELAY, 32'h0);
        rdc(ADDR_GENERATOR_AUX_CONTROL, 32'h0);
        rdc(ADDR_TIME_BASE_CAPTURE, 32'h0);
        wr(ADDR_EDGE_BLANK_DELAY, 32'hffffffff);
        rdc(ADDR_EDGE_BLANK_DELAY, 32'h00000ff8);
        wr(ADDR_GENERATOR_AUX_CONTROL, 32'hffffffff);
        rdc(ADDR_GENERATOR_AUX_CONTROL, 32'h0000cf3f);
        wr(ADDR_TIME_BASE_CAPTURE, 32'h0000ffff);
        rdc(ADDR_TIME_BASE_CAPTURE, 32'h0);
        apb(1'b0, 12'h018, 32'h0, r, e);
        chk({r[30:0], e}, 32'h1);
        for (i = 0; i < 2; i++) begin
            wr(ADDR_GENERATOR_AUX_CONTROL, 32'h8000 >> i);
            cyc(2);
            chk(32'({FINE_PERIOD_ENABLE, FINE_DUTY_ENABLE}), i ? 32'h2 : 32'h1);
        end
        LIMIT_IN <= 1'b1;
        FAULT_IN <= 1'b1;
        wr(ADDR_GENERATOR_AUX_CONTROL, 32'h0);
        for (i = 0; i < 4; i++) for (lev = 0; lev < 2; lev++) begin
            wr(ADDR_EDGE_BLANK_CONTROL, 32'(1 << i));
            PRIMARY_OUTPUT <= lev[0];
            SECONDARY_OUTPUT <= lev[0];
            cyc(6);
            chk(32'({LIMIT_OUT, FAULT_OUT}), (i % 2 == lev) ? 32'h0 : 32'h3);
        end
        // select codes 1..3 each get their own one-hot so a wrong decode shows; codes 0 and 4 drive all three
        for (sel = 0; sel < 5; sel++) for (m = 0; m < 2; m++) for (lev = 0; lev < 2; lev++) begin
            oh = (sel >= 1 && sel <= 3) ? 3'(1 << (sel - 1)) : 3'b111;
            wr(ADDR_EDGE_BLANK_CONTROL, m ? 32'h10 : 32'h20);
            wr(ADDR_GENERATOR_AUX_CONTROL, 32'(sel << 8));
            GENERATOR_PRIMARIES <= lev ? oh : ~oh;
            cyc(3);
            chk(32'(LIMIT_OUT), (sel >= 1 && sel <= 3 && lev != m) ? 32'h0 : 32'h1);
        end
        wr(ADDR_EDGE_BLANK_CONTROL, 32'h0);
        wr(ADDR_CHOP_DIVIDER, 32'h0);
        PRIMARY_OUTPUT <= 1'b1;
        SECONDARY_OUTPUT <= 1'b1;
        for (sel = 0; sel < 5; sel++) for (en = 1; en < 3; en++) for (lev = 0; lev < 2; lev++) begin
            oh = (sel >= 1 && sel <= 3) ? 3'(1 << (sel - 1)) : 3'b111;
            wr(ADDR_GENERATOR_AUX_CONTROL, 32'((sel << 2) | en));
            GENERATOR_PRIMARIES <= lev ? oh : ~oh;
            cyc(3);
            e = (sel >= 1 && sel <= 3 && lev == 1);
            chk(32'({PRIMARY_GATED, SECONDARY_GATED}), 32'({en[1] ? e : 1'b1, en[0] ? e : 1'b1}));
        end
        wr(ADDR_CHOP_DIVIDER, 32'h4);
        wr(ADDR_GENERATOR_AUX_CONTROL, 32'h2);
        cnt = 0;
        prev = PRIMARY_GATED;
        repeat (40) begin
            @(posedge CLK);
            cnt += (PRIMARY_GATED !== prev);
            prev = PRIMARY_GATED;
        end
        chk(32'(cnt >= 4), 32'h1);
        wr(ADDR_GENERATOR_AUX_CONTROL, 32'h0);
        PRIMARY_OUTPUT <= 1'b0;
        LIMIT_IN <= 1'b0;
        TIME_BASE <= 13'h1a5b;
        wr(ADDR_EDGE_BLANK_DELAY, 32'(20 << 3));
        cyc(8);
        LIMIT_IN <= 1'b1;
        cyc(8);
        rdc(ADDR_TIME_BASE_CAPTURE, 32'h0000d2d8);
        LIMIT_IN <= 1'b0;
        TIME_BASE <= 13'h0123;
        wr(ADDR_EDGE_BLANK_CONTROL, 32'h8400);
        cyc(8);
        PRIMARY_OUTPUT <= 1'b1;
        LIMIT_IN <= 1'b1;
        cyc(10);
        chk(32'({LIMIT_OUT, FAULT_OUT}), 32'h1);
        // pulse ends well inside the 20-cycle window
        LIMIT_IN <= 1'b0;
        cyc(24);
        rdc(ADDR_TIME_BASE_CAPTURE, 32'h0000d2d8);
        EXTERNAL_PERIOD_RESET <= 1'b1;
        LIMIT_IN <= 1'b1;
        cyc(8);
        chk(32'(LIMIT_OUT), 32'h1);
        rdc(ADDR_TIME_BASE_CAPTURE, 32'h0000d2d8);
        PRIMARY_OUTPUT <= 1'b0;
        cyc(4);
        chk(32'(LIMIT_OUT), 32'h1);
        LIMIT_IN <= 1'b0;
        EXTERNAL_PERIOD_RESET <= 1'b0;
        cyc(8);
        LIMIT_IN <= 1'b1;
        cyc(8);
        rdc(ADDR_TIME_BASE_CAPTURE, 32'h00000918);
        final_report();
    end
endmodule

bind blank_chop_capture blank_chop_capture_asserts i_blank_chop_capture_asserts (.CLK(CLK),
    .SYS_RST(SYS_RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .PRIMARY_OUTPUT(PRIMARY_OUTPUT), .SECONDARY_OUTPUT(SECONDARY_OUTPUT),
    .PRIMARY_GATED(PRIMARY_GATED), .SECONDARY_GATED(SECONDARY_GATED),
    .FINE_PERIOD_ENABLE(FINE_PERIOD_ENABLE), .FINE_DUTY_ENABLE(FINE_DUTY_ENABLE));
